// File: rts_params.svh
// Timing counts, offsets, field positions and reset values of the sequencer.
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define RTS_CLK_MHZ        100
`define RTS_RC_TICK_NS     1000
`define RTS_RC_TICK_CYC    ((`RTS_RC_TICK_NS * `RTS_CLK_MHZ) / 1000)
`define RTS_POWER_UP_DELAY_TIMER_MS        72
`define RTS_POWER_UP_DELAY_TIMER_TICKS     ((`RTS_POWER_UP_DELAY_TIMER_MS * 1000000) / `RTS_RC_TICK_NS)
`define RTS_OST_EDGES      1024
`define RTS_CPU_DELAY_US   10
`define RTS_CPU_DELAY_CYC  (`RTS_CPU_DELAY_US * `RTS_CLK_MHZ)
`define RTS_BOR_US         100
`define RTS_BOR_CYC        (`RTS_BOR_US * `RTS_CLK_MHZ)
`define RTS_TIMER_W        17

// ****************************************************************
// Register map
// ****************************************************************
`define RTS_ADDR_FLAGS     12'h000
`define RTS_ADDR_CFG       12'h004
`define RTS_ADDR_STATE     12'h008
`define RTS_BIT_BOR_N      0
`define RTS_BIT_POR_N      1
`define RTS_BIT_TIMEOUT    2
`define RTS_BIT_PWRDOWN    3
`define RTS_CFG_POWER_UP_DELAY_TIMER_N     0
`define RTS_CFG_BOR_EN     1
`define RTS_CFG_OSC_LSB    2
`define RTS_CFG_RESET      5'h1f
`define RTS_FLAGS_RESET    4'hc

// ****************************************************************
// Oscillator modes and program counter values
// ****************************************************************
`define RTS_OSC_LP         3'h0
`define RTS_OSC_XT         3'h1
`define RTS_OSC_HS         3'h2
`define RTS_PC_RESET       13'h0000
`define RTS_PC_VECTOR      13'h0004

`endif

// File: rts_pkg.sv
// Types shared by the reset sequencer modules.
package rts_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    kindNone, kindPor, kindBor, kindMclrRun, kindMclrSleep,
    kindWdtRun, kindWdtWake, kindIntWake
  } rts_kind_type;

  typedef enum logic [2:0] {
    stRun, stSleep, stHold, stPowerUp, stOscSettle, stFinish
  } rts_state_type;

  typedef struct packed {
    logic [2:0] oscMode;
    logic       brownOutDetectEnable;
    logic       powerUpDelayEnableN;
  } rts_cfg_type;

  typedef struct packed {
    logic timeOutFlag;
    logic powerDownFlag;
    logic powerOnFlagN;
    logic brownOutFlagN;
  } rts_flags_type;

endpackage : rts_pkg

// File: rts_timer.sv
// Restartable tick counter used for the delay timers.
`timescale 1ns/10ps
`include "rts_params.svh"

module rts_timer (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     start,
  input  wire logic                     tick,
  input  wire logic [`RTS_TIMER_W-1:0]  target,
  output logic                          done
);
  import rts_pkg::*;

  logic [`RTS_TIMER_W-1:0] count_reg;
  logic                    busy_reg;

  // A new start always wins, so a restart mid-count begins from zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
      done      <= 1'b0;
    end else if (start) begin
      count_reg <= '0;
      busy_reg  <= 1'b1;
      done      <= 1'b0;
    end else if (busy_reg && tick) begin
      if (count_reg == target - 1'b1) begin
        busy_reg <= 1'b0;
        done     <= 1'b1;
      end
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule : rts_timer

// File: reset_timeout_sequencer.sv
// Reset source combiner, time-out sequencer and reset-cause flags.
`timescale 1ns/10ps
`include "rts_params.svh"

module reset_timeout_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_TICKS    = `RTS_POWER_UP_DELAY_TIMER_TICKS,
  parameter int BOR_FILTER_CYC = `RTS_BOR_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 powerOnPulse,
  input  wire logic                 lowSupply,
  input  wire logic                 external_reset_n,
  input  wire logic                 primary_osc_input,
  input  wire logic                 watchdogEvent,
  input  wire logic                 interruptWake,
  input  wire logic                 sleepEnter,
  input  wire logic                 global_interrupt_enable,
  output logic                      coreResetOut,
  output logic                      coreRunOut,
  output logic                      pcLoadPulse,
  output logic      [12:0]          pcLoadValue,
  output logic                      resumePulse,
  output logic                      regInitPulse,
  output logic                      wakeFlagPulse,
  output rts_pkg::rts_flags_type    flagsOut
);
  import rts_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic isCrystal(input logic [2:0] mode);
    isCrystal = (mode == `RTS_OSC_LP) || (mode == `RTS_OSC_XT) ||
                (mode == `RTS_OSC_HS);
  endfunction : isCrystal

  function automatic logic isWake(input rts_kind_type k);
    isWake = (k == kindWdtWake) || (k == kindIntWake);
  endfunction : isWake

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  logic       porDelay_reg;
  logic       oscDelay_reg;
  logic       porS;
  logic       lowS;
  logic       mclrS;
  logic       oscS;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinMeta_reg <= 4'h4;
      pinSync_reg <= 4'h4;
    end else begin
      pinMeta_reg <= {primary_osc_input, external_reset_n, lowSupply,
                      powerOnPulse};
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign porS  = pinSync_reg[0];
  assign lowS  = pinSync_reg[1];
  assign mclrS = pinSync_reg[2];
  assign oscS  = pinSync_reg[3];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      porDelay_reg <= 1'b0;
      oscDelay_reg <= 1'b0;
    end else begin
      porDelay_reg <= porS;
      oscDelay_reg <= oscS;
    end
  end

  // ****************************************************************
  // Configuration and event detection
  // ****************************************************************
  rts_cfg_type cfg_reg;
  logic        porEvt;
  logic        borEvt;
  logic        oscEdge;
  logic [13:0] borCnt_reg;
  logic        borFired_reg;
  logic [6:0]  rcDiv_reg;
  logic        rcTick_reg;

  assign porEvt  = porS && !porDelay_reg;
  assign oscEdge = oscS && !oscDelay_reg;

  // The filter fires once per low period; short dips are ignored.
  always_ff @(posedge clk_sys) begin
    if (rst || !lowS || !cfg_reg.brownOutDetectEnable) begin
      borCnt_reg   <= '0;
      borFired_reg <= 1'b0;
    end else if (!borFired_reg) begin
      if (borCnt_reg == 14'(BOR_FILTER_CYC - 1)) begin
        borFired_reg <= 1'b1;
      end
      borCnt_reg <= borCnt_reg + 1'b1;
    end
  end

  assign borEvt = lowS && cfg_reg.brownOutDetectEnable && !borFired_reg &&
                  (borCnt_reg == 14'(BOR_FILTER_CYC - 1));

  // Stand-in for the internal RC clock as an enable pulse.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rcDiv_reg  <= '0;
      rcTick_reg <= 1'b0;
    end else if (rcDiv_reg == 7'(`RTS_RC_TICK_CYC - 1)) begin
      rcDiv_reg  <= '0;
      rcTick_reg <= 1'b1;
    end else begin
      rcDiv_reg  <= rcDiv_reg + 1'b1;
      rcTick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Delay timers
  // ****************************************************************
  logic startPwrt;
  logic startOst;
  logic startCpu;
  logic pwrtDone;
  logic ostDone;
  logic cpuDone;

  rts_timer u_power_up_delay_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (startPwrt),
    .tick    (rcTick_reg),
    .target  (`RTS_TIMER_W'(POWER_UP_DELAY_TIMER_TICKS)),
    .done    (pwrtDone)
  );

  rts_timer u_ost (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (startOst),
    .tick    (oscEdge),
    .target  (`RTS_TIMER_W'(`RTS_OST_EDGES)),
    .done    (ostDone)
  );

  rts_timer u_cpu (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (startCpu),
    .tick    (1'b1),
    .target  (`RTS_TIMER_W'(`RTS_CPU_DELAY_CYC)),
    .done    (cpuDone)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  rts_state_type state_reg;
  rts_state_type state_next;
  rts_kind_type  kind_reg;
  rts_kind_type  kind_next;
  logic          needCpu_reg;
  logic          needCpu_next;
  logic          release_s;
  logic          holdClear;
  logic          oscStep;

  assign holdClear = !porS && !(lowS && cfg_reg.brownOutDetectEnable);
  assign oscStep   = isCrystal(cfg_reg.oscMode) &&
                     ((kind_reg == kindPor) || isWake(kind_reg));

  always_comb begin
    state_next   = state_reg;
    kind_next    = kind_reg;
    needCpu_next = needCpu_reg;
    startPwrt    = 1'b0;
    startOst     = 1'b0;
    startCpu     = 1'b0;
    release_s    = 1'b0;
    if (porEvt) begin
      state_next = stHold;
      kind_next  = kindPor;
    end else if (borEvt) begin
      state_next = stHold;
      kind_next  = kindBor;
    end else begin
      case (state_reg)
        stRun: begin
          if (!mclrS) begin
            state_next = stHold;
            kind_next  = kindMclrRun;
          end else if (watchdogEvent) begin
            state_next   = stFinish;
            kind_next    = kindWdtRun;
            needCpu_next = 1'b0;
          end else if (sleepEnter) begin
            state_next = stSleep;
          end
        end
        stSleep: begin
          if (!mclrS) begin
            state_next = stHold;
            kind_next  = kindMclrSleep;
          end else if (watchdogEvent || interruptWake) begin
            kind_next    = watchdogEvent ? kindWdtWake : kindIntWake;
            startCpu     = 1'b1;
            needCpu_next = 1'b1;
            if (isCrystal(cfg_reg.oscMode)) begin
              startOst   = 1'b1;
              state_next = stOscSettle;
            end else begin
              state_next = stFinish;
            end
          end
        end
        stHold: begin
          if ((kind_reg == kindPor) || (kind_reg == kindBor)) begin
            if (holdClear) begin
              startCpu     = 1'b1;
              needCpu_next = 1'b1;
              if (!cfg_reg.powerUpDelayEnableN) begin
                startPwrt  = 1'b1;
                state_next = stPowerUp;
              end else if (oscStep) begin
                startOst   = 1'b1;
                state_next = stOscSettle;
              end else begin
                state_next = stFinish;
              end
            end
          end else begin
            needCpu_next = 1'b0;
            state_next   = stFinish;
          end
        end
        stPowerUp: begin
          if (lowS && cfg_reg.brownOutDetectEnable) begin
            state_next = stHold;
            kind_next  = kindBor;
          end else if (pwrtDone) begin
            if (oscStep) begin
              startOst   = 1'b1;
              state_next = stOscSettle;
            end else begin
              state_next = stFinish;
            end
          end
        end
        stOscSettle: begin
          if (ostDone) begin
            state_next = stFinish;
          end
        end
        stFinish: begin
          if (mclrS && (cpuDone || !needCpu_reg)) begin
            release_s  = 1'b1;
            state_next = isWake(kind_reg) ? stRun : stRun;
          end
        end
        default: begin
          state_next = stHold;
          kind_next  = kindPor;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= stHold;
      kind_reg    <= kindPor;
      needCpu_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      kind_reg    <= kind_next;
      needCpu_reg <= needCpu_next;
    end
  end

  // ****************************************************************
  // Core control outputs
  // ****************************************************************
  logic resetKind;
  assign resetKind = !isWake(kind_next) && (kind_next != kindNone);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      coreResetOut <= 1'b1;
      coreRunOut   <= 1'b0;
    end else begin
      coreResetOut <= (state_next != stRun) && (state_next != stSleep) &&
                      resetKind;
      coreRunOut   <= (state_next == stRun);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcLoadPulse   <= 1'b0;
      pcLoadValue   <= `RTS_PC_RESET;
      resumePulse   <= 1'b0;
      regInitPulse  <= 1'b0;
      wakeFlagPulse <= 1'b0;
    end else begin
      pcLoadPulse   <= 1'b0;
      resumePulse   <= 1'b0;
      regInitPulse  <= 1'b0;
      wakeFlagPulse <= 1'b0;
      if (release_s) begin
        if (!isWake(kind_reg)) begin
          pcLoadPulse  <= 1'b1;
          pcLoadValue  <= `RTS_PC_RESET;
          regInitPulse <= 1'b1;
        end else if ((kind_reg == kindIntWake) &&
                     global_interrupt_enable) begin
          pcLoadPulse   <= 1'b1;
          pcLoadValue   <= `RTS_PC_VECTOR;
          wakeFlagPulse <= 1'b1;
        end else begin
          resumePulse   <= 1'b1;
          wakeFlagPulse <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Reset-cause flags and register bus
  // ****************************************************************
  logic apbAccess;
  logic apbDone;
  logic wrFlags;

  assign apbAccess = psel && penable;
  assign apbDone   = apbAccess && pready;
  assign wrFlags   = apbDone && pwrite && (paddr == `RTS_ADDR_FLAGS);

  // Hardware clears win over a software set in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flagsOut <= `RTS_FLAGS_RESET;
    end else begin
      if (wrFlags) begin
        flagsOut.brownOutFlagN <= pwdata[`RTS_BIT_BOR_N];
        flagsOut.powerOnFlagN  <= pwdata[`RTS_BIT_POR_N];
      end
      if (porEvt) begin
        flagsOut.powerOnFlagN <= 1'b0;
      end
      if (!porEvt && borEvt) begin
        flagsOut.brownOutFlagN <= 1'b0;
      end
      if (kind_next != kind_reg || porEvt || borEvt) begin
        case (kind_next)
          kindPor, kindBor: begin
            flagsOut.timeOutFlag   <= 1'b1;
            flagsOut.powerDownFlag <= 1'b1;
          end
          kindWdtRun: begin
            flagsOut.timeOutFlag   <= 1'b0;
            flagsOut.powerDownFlag <= 1'b1;
          end
          kindWdtWake: begin
            flagsOut.timeOutFlag   <= 1'b0;
            flagsOut.powerDownFlag <= 1'b0;
          end
          kindMclrSleep, kindIntWake: begin
            flagsOut.timeOutFlag   <= 1'b1;
            flagsOut.powerDownFlag <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= `RTS_CFG_RESET;
    end else if (apbDone && pwrite && (paddr == `RTS_ADDR_CFG)) begin
      cfg_reg <= pwdata[4:0];
    end
  end

  // One wait state; the access completes at the second edge after penable rises.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apbAccess && !pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (apbAccess && !pready) begin
        case (paddr)
          `RTS_ADDR_FLAGS: prdata <= {28'h0, flagsOut};
          `RTS_ADDR_CFG:   prdata <= {27'h0, cfg_reg};
          `RTS_ADDR_STATE: prdata <= {25'h0, coreResetOut,
                                      state_reg, kind_reg};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : reset_timeout_sequencer

// File: rts_checker_asserts.sv
// Port-level assertions for the reset time-out sequencer.
`timescale 1ns/10ps
`include "rts_params.svh"
module rts_checker #(
  parameter int POWER_UP_DELAY_TIMER_TICKS     = `RTS_POWER_UP_DELAY_TIMER_TICKS,
  parameter int BOR_FILTER_CYC = `RTS_BOR_CYC
) (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   lowSupply,
  input wire logic                   external_reset_n,
  input wire logic                   watchdogEvent,
  input wire logic                   coreResetOut,
  input wire logic                   coreRunOut,
  input wire logic                   pcLoadPulse,
  input wire logic [12:0]            pcLoadValue,
  input wire logic                   resumePulse,
  input wire logic                   regInitPulse,
  input wire logic                   wakeFlagPulse,
  input wire rts_pkg::rts_flags_type flagsOut
);
  import rts_pkg::*;
  int lowCnt_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ****************************************************************
  // Checks
  // ****************************************************************
  // The count saturates so a long brown-out cannot wrap it.
  always_ff @(posedge clk_sys) begin
    if (rst || !lowSupply) lowCnt_reg <= 0;
    else if (lowCnt_reg < 1000000) lowCnt_reg <= lowCnt_reg + 1;
  end
  apb_wait_a:
    assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer is not one cycle wide");
  bor_filter_a:
    assert property ($fell(flagsOut.brownOutFlagN) && !$past(pready)
      |-> lowCnt_reg >= BOR_FILTER_CYC) else $error("Brown-out too early");
  por_flags_a:
    assert property ($fell(flagsOut.powerOnFlagN) && !$past(pready) |->
      ##[0:2] (coreResetOut && flagsOut.timeOutFlag
      && flagsOut.powerDownFlag)) else $error("Power-on flags wrong");
  wdt_flags_a:
    assert property (watchdogEvent && coreRunOut |-> ##[1:4]
      (!flagsOut.timeOutFlag && flagsOut.powerDownFlag))
    else $error("Watchdog reset flags wrong");
  reset_load_a:
    assert property (regInitPulse |-> pcLoadPulse
      && pcLoadValue == `RTS_PC_RESET) else $error("Reset load not zero");
  wake_keep_a:
    assert property (resumePulse || wakeFlagPulse |-> !regInitPulse
      && !(resumePulse && pcLoadPulse)) else $error("Wake reinitialised");
  pin_hold_a:
    assert property (!external_reset_n [*6] |-> !coreRunOut)
    else $error("Core runs with pin low");
  reset_excl_a:
    assert property (coreResetOut |-> !coreRunOut)
    else $error("Core runs while in reset");
  cover property (regInitPulse);
  cover property (resumePulse);
  cover property (pcLoadPulse && pcLoadValue == `RTS_PC_VECTOR);
endmodule : rts_checker

bind reset_timeout_sequencer rts_checker #(
  .POWER_UP_DELAY_TIMER_TICKS(POWER_UP_DELAY_TIMER_TICKS),
  .BOR_FILTER_CYC(BOR_FILTER_CYC)
) chkInst (
  .clk_sys, .rst, .psel, .penable, .pready, .lowSupply, .external_reset_n,
  .watchdogEvent, .coreResetOut, .coreRunOut, .pcLoadPulse, .pcLoadValue,
  .resumePulse, .regInitPulse, .wakeFlagPulse, .flagsOut
);

// File: rts_supply_model.sv
// Behavioural supply monitor, external reset pin and crystal source.
`timescale 1ns/10ps
module rts_supply_model (
  input  wire logic clk_sys,
  output logic      powerOnPulse,
  output logic      lowSupply,
  output logic      external_reset_n,
  output logic      primary_osc_input
);
  // ****************************************************************
  // Sources
  // ****************************************************************
  initial begin
    powerOnPulse = 1'b0;
    lowSupply = 1'b0;
    external_reset_n = 1'b1;
    primary_osc_input = 1'b0;
  end
  // Period 30.2 ns keeps crystal edges drifting against the clock.
  always #15.1 primary_osc_input = ~primary_osc_input;
  task automatic power_on(input logic pinLow);
    @(posedge clk_sys);
    powerOnPulse <= 1'b1;
    external_reset_n <= !pinLow;
    repeat (3) @(posedge clk_sys);
    powerOnPulse <= 1'b0;
    // One more edge lets the core outputs show the reset before anyone looks.
    @(posedge clk_sys);
  endtask : power_on
  task automatic drop_supply(input int n);
    @(posedge clk_sys);
    lowSupply <= 1'b1;
    repeat (n) @(posedge clk_sys);
    lowSupply <= 1'b0;
  endtask : drop_supply
  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    external_reset_n <= v;
  endtask : set_pin
endmodule : rts_supply_model

// File: reset_timeout_sequencer_tb.sv
// Self-checking bench for the reset time-out sequencer.
`timescale 1ns/10ps
`include "rts_params.svh"
module reset_timeout_sequencer_tb;
  import rts_pkg::*;
  localparam int PT = 20;
  localparam int BF = 8;
  localparam int POWER_UP_DELAY_TIMER_CYC = PT * 100;
  // The RC tick runs free, so the first tick lands anywhere in one period.
  localparam int POWER_UP_DELAY_TIMER_MIN = POWER_UP_DELAY_TIMER_CYC - 100;
  localparam int CPU_CYC = `RTS_CPU_DELAY_CYC;
  // Lower bound: 1023 whole crystal periods after the count starts.
  localparam int OST_CYC = 3089;
  localparam int SLACK = 40;
  logic          clk_sys = 1'b0;
  logic          rst;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [2:0]    ev;
  logic          global_interrupt_enable;
  logic [31:0]   prdata, rdData;
  logic          pready, pslverr, rdErr;
  logic          powerOnPulse, lowSupply, external_reset_n;
  logic          primary_osc_input, coreResetOut, coreRunOut;
  logic          pcLoadPulse, resumePulse, regInitPulse, wakeFlagPulse;
  logic [12:0]   pcLoadValue;
  logic [12:0]   lastPc = 13'h1fff;
  logic          sawResume = 1'b0;
  rts_flags_type flagsOut;
  int            nMismatch = 0;
  int            cmpCount = 0;
  int            cycles = 0;
  reset_timeout_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(PT), .BOR_FILTER_CYC(BF)) uut (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .powerOnPulse, .lowSupply, .external_reset_n,
    .primary_osc_input, .watchdogEvent(ev[0]), .interruptWake(ev[1]),
    .sleepEnter(ev[2]), .global_interrupt_enable, .coreResetOut,
    .coreRunOut, .pcLoadPulse, .pcLoadValue, .resumePulse, .regInitPulse,
    .wakeFlagPulse, .flagsOut
  );
  rts_supply_model sup (
    .clk_sys, .powerOnPulse, .lowSupply, .external_reset_n,
    .primary_osc_input
  );
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  always #5 clk_sys = ~clk_sys;
  // One-cycle pulses are caught mid-cycle so a check at the next edge sees them.
  always @(negedge clk_sys) begin
    if (pcLoadPulse === 1'b1) lastPc <= pcLoadValue;
    if (resumePulse === 1'b1) sawResume <= 1'b1;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      nMismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, m,
                    input string msg);
    apb(1'b0, a, 32'h0);
    chk(rdData & m, exp, msg);
  endtask : rd
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 3'h0;
  endtask : pulse
  task automatic wait_run(output int n);
    n = 0;
    while (coreRunOut !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_run
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    int n;
    rd(`RTS_ADDR_FLAGS, 32'hc, 32'hf, "flags reset");
    rd(`RTS_ADDR_CFG, 32'h1f, 32'h1f, "config reset");
    rd(12'h00c, 32'h0, 32'hffffffff, "unmapped data");
    chk({31'h0, rdErr}, 32'h1, "unmapped error");
    apb(1'b1, `RTS_ADDR_FLAGS, 32'h3);
    rd(`RTS_ADDR_FLAGS, 32'hf, 32'hf, "flag set");
    wait_run(n);
    chk({31'h0, coreRunOut}, 32'h1, "run after reset");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rc();
    int n;
    sup.power_on(1'b0);
    wait_run(n);
    chk(32'(n >= CPU_CYC && n <= CPU_CYC + SLACK), 1, "cpu delay");
    rd(`RTS_ADDR_FLAGS, 32'hc, 32'he, "por flags");
    $display("t_rc done");
  endtask : t_rc
  task automatic t_xt();
    int n;
    apb(1'b1, `RTS_ADDR_CFG, 32'h06);
    sup.power_on(1'b0);
    wait_run(n);
    chk(32'(n >= POWER_UP_DELAY_TIMER_MIN + OST_CYC && n <= POWER_UP_DELAY_TIMER_CYC + OST_CYC + SLACK),
        1, "crystal power-up");
    sup.power_on(1'b1);
    repeat (POWER_UP_DELAY_TIMER_CYC + OST_CYC + 200) @(posedge clk_sys);
    chk({31'h0, coreRunOut}, 32'h0, "held by pin");
    sup.set_pin(1'b1);
    wait_run(n);
    chk(32'(n <= 8), 1, "run on pin release");
    $display("t_xt done");
  endtask : t_xt
  task automatic t_brown();
    int n;
    apb(1'b1, `RTS_ADDR_CFG, 32'h1e);
    apb(1'b1, `RTS_ADDR_FLAGS, 32'h3);
    sup.drop_supply(BF - 4);
    repeat (20) @(posedge clk_sys);
    chk({31'h0, coreRunOut}, 32'h1, "short dip");
    sup.drop_supply(40);
    repeat (500) @(posedge clk_sys);
    sup.drop_supply(40);
    wait_run(n);
    chk(32'(n >= POWER_UP_DELAY_TIMER_MIN && n <= POWER_UP_DELAY_TIMER_CYC + SLACK), 1, "restart");
    rd(`RTS_ADDR_FLAGS, 32'he, 32'hf, "brown-out flags");
    $display("t_brown done");
  endtask : t_brown
  task automatic t_sleep();
    int n;
    pulse(3'b100);
    repeat (4) @(posedge clk_sys);
    chk({30'h0, coreRunOut, coreResetOut}, 32'h0, "asleep");
    sawResume = 1'b0;
    pulse(3'b001);
    wait_run(n);
    chk(32'(n >= CPU_CYC - 4 && n <= CPU_CYC + SLACK), 1, "wake");
    chk({31'h0, sawResume}, 32'h1, "resume");
    rd(`RTS_ADDR_FLAGS, 32'h0, 32'hc, "watchdog wake");
    pulse(3'b100);
    global_interrupt_enable <= 1'b1;
    pulse(3'b010);
    wait_run(n);
    chk({19'h0, lastPc}, 32'h4, "vector");
    rd(`RTS_ADDR_FLAGS, 32'h8, 32'hc, "interrupt wake");
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_wdt();
    int n;
    lastPc = 13'h1fff;
    pulse(3'b001);
    repeat (10) @(posedge clk_sys);
    wait_run(n);
    chk({19'h0, lastPc}, 32'h0, "watchdog load");
    rd(`RTS_ADDR_FLAGS, 32'h4, 32'hc, "watchdog reset");
    pulse(3'b100);
    sup.set_pin(1'b0);
    repeat (10) @(posedge clk_sys);
    sup.set_pin(1'b1);
    wait_run(n);
    rd(`RTS_ADDR_FLAGS, 32'h8, 32'hc, "pin in sleep");
    $display("t_wdt done");
  endtask : t_wdt
  initial begin
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    ev <= 3'h0;
    global_interrupt_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_rc();
    t_xt();
    t_brown();
    t_sleep();
    t_wdt();
    stop_test();
  end
endmodule : reset_timeout_sequencer_tb
